// ### uau_pkg.sv
`default_nettype none
package uau_pkg;
  localparam logic [3:0] PHASE_MID = 4'h7;
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_RST = 3'h0;
  localparam logic [15:0] DIVIDER_MIN = 16'h0001;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] SCHEME_ALL = 2'h0;
  localparam logic [1:0] SCHEME_ADDR_ONLY = 2'h1;
  localparam logic [1:0] SCHEME_MATCH = 2'h2;
  localparam logic [1:0] SCHEME_MATCH_DATA = 2'h3;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_NINTH = 5'h08, TX_STOP = 5'h10
  } uau_tx_state_t;

  typedef enum logic [5:0] {
    RX_IDLE = 6'h01, RX_START = 6'h02, RX_DATA = 6'h04, RX_NINTH = 6'h08,
    RX_STOP = 6'h10, RX_BRKW = 6'h20
  } uau_rx_state_t;

  function automatic logic uau_parity(input logic [7:0] data, input logic odd);
    return (^data) ^ odd;
  endfunction : uau_parity
endpackage : uau_pkg
`default_nettype wire

// ### uau_baud_if.sv
`default_nettype none
interface uau_baud_if;
  logic [15:0] divider;
  logic run;
  logic tick;
  modport gen (input divider, input run, output tick);
  modport user (output divider, output run, input tick);
endinterface : uau_baud_if
`default_nettype wire

// ### uau_baud_gen.sv
`default_nettype none
// One tick every divider clocks; the serial logic divides a bit into 16 ticks.
module uau_baud_gen (
  input wire logic clk,
  input wire logic arst_n,
  uau_baud_if.gen bus
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    tick_d = 1'b0;
    if (!bus.run || cnt_q <= uau_pkg::DIVIDER_MIN) begin
      // A zero divider behaves as one so the counter can never stall.
      cnt_d = (bus.divider < uau_pkg::DIVIDER_MIN) ? uau_pkg::DIVIDER_MIN : bus.divider;
      tick_d = bus.run;
    end else begin
      cnt_d = cnt_q - uau_pkg::DIVIDER_MIN;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= uau_pkg::COUNT_RST;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign bus.tick = tick_q;
endmodule : uau_baud_gen
`default_nettype wire

// ### uau_uart.sv
// Functional notes
// - 8-bit characters with optional even/odd parity
// - One or two stop bits on transmit
// - 16-bit divider, also usable as timer
// - Independent enables, shared baud and format
// - Flag framing, parity, overrun and break
// - Scheme 01: address bytes only interrupt
// - Scheme 00: all bytes, flag marks address
// - Scheme 10: compare address, drop mismatched frames
// - First data byte of matched frame flagged
// - Scheme 11: like 10, address bytes silent
// - Drive-enable output for external transceiver
// - Holding empty as soon as shift loads
// - Writing transmit data clears holding empty
// - Receive interrupt; data source separately maskable
// - Overrun keeps held character intact
// - Overrun and break shown after held read
// - Break flag tells break caused overrun
// - Status then data read clears errors
`default_nettype none
module uau_uart (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic TX_ENABLE,
  input wire logic RX_ENABLE,
  input wire logic PARITY_ENABLE,
  input wire logic PARITY_ODD,
  input wire logic TWO_STOP,
  input wire logic [15:0] BAUD_DIVIDER,
  input wire logic TIMER_MODE,
  input wire logic MULTIPROC_ENABLE,
  input wire logic [1:0] MULTIPROC_SCHEME_SEL,
  input wire logic [7:0] ADDR_COMPARE,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_ADDR_BIT,
  input wire logic TX_DATA_WR,
  input wire logic RX_DATA_RD,
  input wire logic STATUS_RD,
  input wire logic RX_DATA_IRQ_EN,
  input wire logic RXD,
  output logic TXD,
  output logic TRANSCEIVER_DRIVE_ENABLE,
  output logic TX_HOLDING_EMPTY,
  output logic TX_IRQ,
  output logic [7:0] RX_DATA,
  output logic RX_BYTE_AVAILABLE,
  output logic PARITY_ERR,
  output logic FRAMING_ERR,
  output logic OVERRUN_ERR,
  output logic LINE_BREAK_FLAG,
  output logic RX_FRAME_START_FLAG,
  output logic FIRST_DATA_OF_FRAME_FLAG,
  output logic RX_IRQ,
  output logic TIMER_EVENT
);
  ////////////////////////////////////////////////////////////////////////////////
  uau_baud_if bif ();
  assign bif.divider = BAUD_DIVIDER;
  assign bif.run = TX_ENABLE | RX_ENABLE | TIMER_MODE;
  uau_baud_gen u_baud (.clk(CORE_CLK), .arst_n(ARST_N), .bus(bif));

  logic tick;
  logic ninth_used;
  assign tick = bif.tick;
  assign ninth_used = PARITY_ENABLE | MULTIPROC_ENABLE;

  logic timer_q;
  logic timer_d;
  logic txirq_q;
  logic txirq_d;
  always_comb begin
    timer_d = tick & TIMER_MODE;
    txirq_d = TX_HOLDING_EMPTY & TX_ENABLE;
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_q <= 1'b0;
      txirq_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      txirq_q <= txirq_d;
    end
  end
  assign TIMER_EVENT = timer_q;
  assign TX_IRQ = txirq_q;

  ////////////////////////////////////////////////////////////////////////////////
  uau_pkg::uau_tx_state_t tx_state_q, tx_state_d;
  logic [3:0] tx_phase_q, tx_phase_d;
  logic [2:0] tx_bit_q, tx_bit_d;
  logic [7:0] tx_shift_q, tx_shift_d, tx_hold_q, tx_hold_d;
  logic tx_hold_addr_q, tx_hold_addr_d, tx_ninth_q, tx_ninth_d;
  logic tx_holding_empty_q, tx_holding_empty_d, txd_q, txd_d, de_q, de_d, stop2_q, stop2_d;
  logic tx_adv;

  always_comb begin
    tx_state_d = tx_state_q;
    tx_phase_d = tick ? tx_phase_q + 4'h1 : tx_phase_q;
    tx_bit_d = tx_bit_q;
    tx_shift_d = tx_shift_q;
    tx_hold_d = tx_hold_q;
    tx_hold_addr_d = tx_hold_addr_q;
    tx_ninth_d = tx_ninth_q;
    tx_holding_empty_d = tx_holding_empty_q;
    txd_d = txd_q;
    stop2_d = stop2_q;
    tx_adv = tick && tx_phase_q == uau_pkg::PHASE_LAST;
    case (tx_state_q)
      uau_pkg::TX_IDLE: begin
        txd_d = 1'b1;
        tx_phase_d = uau_pkg::PHASE_RST;
      end
      uau_pkg::TX_START: begin
        if (tx_adv) begin
          tx_state_d = uau_pkg::TX_DATA;
          tx_bit_d = uau_pkg::BIT_RST;
          txd_d = tx_shift_q[0];
        end
      end
      uau_pkg::TX_DATA: begin
        if (tx_adv) begin
          if (tx_bit_q == uau_pkg::BIT_LAST) begin
            tx_state_d = ninth_used ? uau_pkg::TX_NINTH : uau_pkg::TX_STOP;
            txd_d = ninth_used ? tx_ninth_q : 1'b1;
            stop2_d = TWO_STOP;
          end else begin
            tx_bit_d = tx_bit_q + 3'h1;
            tx_shift_d = {1'b0, tx_shift_q[7:1]};
            txd_d = tx_shift_q[1];
          end
        end
      end
      uau_pkg::TX_NINTH: begin
        if (tx_adv) begin
          tx_state_d = uau_pkg::TX_STOP;
          txd_d = 1'b1;
        end
      end
      uau_pkg::TX_STOP: begin
        if (tx_adv) begin
          if (stop2_q) begin
            stop2_d = 1'b0;
          end else begin
            tx_state_d = uau_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        tx_state_d = uau_pkg::TX_IDLE;
      end
    endcase
    // Loading at the end of the last stop bit keeps back-to-back characters gap-free.
    if (TX_ENABLE && !tx_holding_empty_q && (tx_state_q == uau_pkg::TX_IDLE ||
        (tx_state_q == uau_pkg::TX_STOP && tx_adv && !stop2_q))) begin
      tx_state_d = uau_pkg::TX_START;
      tx_phase_d = uau_pkg::PHASE_RST;
      tx_shift_d = tx_hold_q;
      // Multiprocessor mode puts the address marker where parity would go.
      tx_ninth_d = MULTIPROC_ENABLE ? tx_hold_addr_q
                                    : uau_pkg::uau_parity(tx_hold_q, PARITY_ODD);
      tx_holding_empty_d = 1'b1;
      txd_d = 1'b0;
    end
    if (TX_DATA_WR) begin
      tx_hold_d = TX_DATA;
      tx_hold_addr_d = TX_ADDR_BIT;
      tx_holding_empty_d = 1'b0;
    end
    de_d = (tx_state_d != uau_pkg::TX_IDLE);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_state_q <= uau_pkg::TX_IDLE;
      tx_phase_q <= uau_pkg::PHASE_RST;
      tx_bit_q <= uau_pkg::BIT_RST;
      tx_shift_q <= uau_pkg::BYTE_RST;
      tx_hold_q <= uau_pkg::BYTE_RST;
      tx_hold_addr_q <= 1'b0;
      tx_ninth_q <= 1'b0;
      tx_holding_empty_q <= 1'b1;
      txd_q <= 1'b1;
      de_q <= 1'b0;
      stop2_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      tx_phase_q <= tx_phase_d;
      tx_bit_q <= tx_bit_d;
      tx_shift_q <= tx_shift_d;
      tx_hold_q <= tx_hold_d;
      tx_hold_addr_q <= tx_hold_addr_d;
      tx_ninth_q <= tx_ninth_d;
      tx_holding_empty_q <= tx_holding_empty_d;
      txd_q <= txd_d;
      de_q <= de_d;
      stop2_q <= stop2_d;
    end
  end
  assign TXD = txd_q;
  assign TRANSCEIVER_DRIVE_ENABLE = de_q;
  assign TX_HOLDING_EMPTY = tx_holding_empty_q;

  ////////////////////////////////////////////////////////////////////////////////
  logic rxd_m_q, rxd_s_q;
  uau_pkg::uau_rx_state_t rx_state_q, rx_state_d;
  logic [3:0] rx_phase_q, rx_phase_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_shift_q, rx_shift_d;
  logic rx_ninth_q, rx_ninth_d;
  logic rx_done, rx_fe, rx_brk, rx_perr, rx_samp, rx_adv;

  always_comb begin
    rx_state_d = rx_state_q;
    rx_phase_d = tick ? rx_phase_q + 4'h1 : rx_phase_q;
    rx_bit_d = rx_bit_q;
    rx_shift_d = rx_shift_q;
    rx_ninth_d = rx_ninth_q;
    rx_done = 1'b0;
    rx_samp = tick && rx_phase_q == uau_pkg::PHASE_MID;
    rx_adv = tick && rx_phase_q == uau_pkg::PHASE_LAST;
    rx_fe = ~rxd_s_q;
    rx_brk = ~rxd_s_q && rx_shift_q == uau_pkg::BYTE_RST && !(ninth_used && rx_ninth_q);
    rx_perr = PARITY_ENABLE && !MULTIPROC_ENABLE &&
              rx_ninth_q != uau_pkg::uau_parity(rx_shift_q, PARITY_ODD);
    case (rx_state_q)
      uau_pkg::RX_IDLE: begin
        rx_phase_d = uau_pkg::PHASE_RST;
        if (RX_ENABLE && !rxd_s_q) begin
          rx_state_d = uau_pkg::RX_START;
        end
      end
      uau_pkg::RX_START: begin
        // A start edge that is high again at mid-bit was a glitch.
        if (rx_samp && rxd_s_q) begin
          rx_state_d = uau_pkg::RX_IDLE;
        end else if (rx_adv) begin
          rx_state_d = uau_pkg::RX_DATA;
          rx_bit_d = uau_pkg::BIT_RST;
        end
      end
      uau_pkg::RX_DATA: begin
        if (rx_samp) begin
          rx_shift_d = {rxd_s_q, rx_shift_q[7:1]};
        end
        if (rx_adv) begin
          if (rx_bit_q == uau_pkg::BIT_LAST) begin
            rx_state_d = ninth_used ? uau_pkg::RX_NINTH : uau_pkg::RX_STOP;
          end else begin
            rx_bit_d = rx_bit_q + 3'h1;
          end
        end
      end
      uau_pkg::RX_NINTH: begin
        if (rx_samp) begin
          rx_ninth_d = rxd_s_q;
        end
        if (rx_adv) begin
          rx_state_d = uau_pkg::RX_STOP;
        end
      end
      uau_pkg::RX_STOP: begin
        if (rx_samp) begin
          rx_done = 1'b1;
          // A held-low line must return high before another start is accepted.
          rx_state_d = rxd_s_q ? uau_pkg::RX_IDLE : uau_pkg::RX_BRKW;
        end
      end
      uau_pkg::RX_BRKW: begin
        if (rxd_s_q) begin
          rx_state_d = uau_pkg::RX_IDLE;
        end
      end
      default: begin
        rx_state_d = uau_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      rx_state_q <= uau_pkg::RX_IDLE;
      rx_phase_q <= uau_pkg::PHASE_RST;
      rx_bit_q <= uau_pkg::BIT_RST;
      rx_shift_q <= uau_pkg::BYTE_RST;
      rx_ninth_q <= 1'b0;
    end else begin
      rxd_m_q <= RXD;
      rxd_s_q <= rxd_m_q;
      rx_state_q <= rx_state_d;
      rx_phase_q <= rx_phase_d;
      rx_bit_q <= rx_bit_d;
      rx_shift_q <= rx_shift_d;
      rx_ninth_q <= rx_ninth_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] rdata_q, rdata_d;
  logic rda_q, rda_d, perr_q, perr_d, fe_q, fe_d, ovr_q, ovr_d, brk_q, brk_d;
  logic fs_q, fs_d, fd_q, fd_d, irq_q, irq_d;
  logic ovr_pend_q, ovr_pend_d, brk_pend_q, brk_pend_d, armed_q, armed_d;
  logic matched_q, matched_d, first_pend_q, first_pend_d;
  logic is_addr, deliver, fs_c, fd_c, rx_store;

  always_comb begin
    rdata_d = rdata_q;
    rda_d = rda_q;
    perr_d = perr_q;
    fe_d = fe_q;
    ovr_d = ovr_q;
    brk_d = brk_q;
    fs_d = fs_q;
    fd_d = fd_q;
    ovr_pend_d = ovr_pend_q;
    brk_pend_d = brk_pend_q;
    armed_d = armed_q;
    matched_d = matched_q;
    first_pend_d = first_pend_q;
    is_addr = MULTIPROC_ENABLE & rx_ninth_q;
    deliver = 1'b1;
    fs_c = 1'b0;
    fd_c = 1'b0;
    rx_store = 1'b0;
    if (STATUS_RD && ovr_q) begin
      armed_d = 1'b1;
    end
    if (RX_DATA_RD && rda_q) begin
      if (armed_q) begin
        {rda_d, ovr_d, brk_d, perr_d, fe_d, armed_d} = 6'h00;
      end else if (ovr_pend_q) begin
        // The discarded byte is flagged only after the good one has been taken.
        ovr_d = 1'b1;
        brk_d = brk_pend_q;
        rda_d = 1'b1;
        ovr_pend_d = 1'b0;
      end else begin
        {rda_d, perr_d, fe_d, brk_d} = 4'h0;
      end
    end
    if (MULTIPROC_ENABLE) begin
      case (MULTIPROC_SCHEME_SEL)
        uau_pkg::SCHEME_ALL: begin
          fs_c = is_addr;
        end
        uau_pkg::SCHEME_ADDR_ONLY: begin
          deliver = is_addr;
          fs_c = is_addr;
        end
        uau_pkg::SCHEME_MATCH, uau_pkg::SCHEME_MATCH_DATA: begin
          if (is_addr) begin
            if (rx_done) begin
              matched_d = (rx_shift_q == ADDR_COMPARE);
              first_pend_d = (rx_shift_q == ADDR_COMPARE);
            end
            deliver = (rx_shift_q == ADDR_COMPARE) &&
                      MULTIPROC_SCHEME_SEL == uau_pkg::SCHEME_MATCH;
            fs_c = 1'b1;
          end else begin
            deliver = matched_q;
            fd_c = first_pend_q;
          end
        end
        default: begin
          deliver = 1'b1;
        end
      endcase
    end
    if (rx_done && deliver) begin
      if (rda_d) begin
        ovr_pend_d = 1'b1;
        brk_pend_d = ovr_pend_q ? brk_pend_q : rx_brk;
      end else begin
        rx_store = 1'b1;
        rdata_d = rx_shift_q;
        rda_d = 1'b1;
        perr_d = rx_perr;
        fe_d = rx_fe;
        brk_d = rx_brk;
        fs_d = fs_c;
        fd_d = fd_c;
        if (!is_addr) begin
          first_pend_d = 1'b0;
        end
      end
    end
    irq_d = (rda_d & RX_DATA_IRQ_EN) | ovr_d | fe_d | brk_d;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= uau_pkg::BYTE_RST;
      {rda_q, perr_q, fe_q, ovr_q, brk_q, fs_q, fd_q, irq_q} <= 8'h00;
      {ovr_pend_q, brk_pend_q, armed_q, matched_q, first_pend_q} <= 5'h00;
    end else begin
      rdata_q <= rdata_d;
      {rda_q, perr_q, fe_q, ovr_q, brk_q, fs_q, fd_q, irq_q} <=
        {rda_d, perr_d, fe_d, ovr_d, brk_d, fs_d, fd_d, irq_d};
      {ovr_pend_q, brk_pend_q, armed_q, matched_q, first_pend_q} <=
        {ovr_pend_d, brk_pend_d, armed_d, matched_d, first_pend_d};
    end
  end
  assign RX_DATA = rdata_q;
  assign RX_BYTE_AVAILABLE = rda_q;
  assign PARITY_ERR = perr_q;
  assign FRAMING_ERR = fe_q;
  assign OVERRUN_ERR = ovr_q;
  assign LINE_BREAK_FLAG = brk_q;
  assign RX_FRAME_START_FLAG = fs_q;
  assign FIRST_DATA_OF_FRAME_FLAG = fd_q;
  assign RX_IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  AST_WR_CLEARS_EMPTY: assert property (TX_DATA_WR |=> !TX_HOLDING_EMPTY)
    else $error("holding empty not cleared by write");
  AST_LOAD_FREES: assert property (
    tx_state_q == uau_pkg::TX_IDLE && TX_ENABLE && !tx_holding_empty_q && !TX_DATA_WR
    |=> TX_HOLDING_EMPTY && tx_state_q == uau_pkg::TX_START && !TXD)
    else $error("load did not free holding register");
  AST_DE_SPAN: assert property (
    (tx_state_q != uau_pkg::TX_IDLE) == TRANSCEIVER_DRIVE_ENABLE)
    else $error("drive enable does not span the character");
  AST_STOP_HIGH: assert property (
    tx_state_q == uau_pkg::TX_STOP |-> TXD && TRANSCEIVER_DRIVE_ENABLE)
    else $error("stop bit not high");
  AST_OVR_KEEPS: assert property (
    rx_done && deliver && rda_q && !RX_DATA_RD |=> $stable(RX_DATA) && ovr_pend_q)
    else $error("overrun overwrote held data");
  AST_OVR_SHOWN: assert property (
    ovr_pend_q && rda_q && RX_DATA_RD && !armed_q
    |=> OVERRUN_ERR && RX_BYTE_AVAILABLE && LINE_BREAK_FLAG == $past(brk_pend_q))
    else $error("overrun not shown after read");
  AST_OVR_CLEAR: assert property (
    armed_q && rda_q && RX_DATA_RD && !rx_done |=> !OVERRUN_ERR && !RX_BYTE_AVAILABLE)
    else $error("second read did not clear errors");
  AST_ADDR_ONLY: assert property (
    rx_done && MULTIPROC_ENABLE && MULTIPROC_SCHEME_SEL == uau_pkg::SCHEME_ADDR_ONLY
    && !rx_ninth_q && !RX_DATA_RD |=> $stable(RX_BYTE_AVAILABLE) && $stable(RX_DATA))
    else $error("data byte delivered in address-only scheme");
  AST_MISMATCH: assert property (
    rx_done && MULTIPROC_ENABLE && MULTIPROC_SCHEME_SEL[1] && !is_addr && !matched_q
    && !RX_DATA_RD |=> $stable(RX_DATA) && $stable(RX_BYTE_AVAILABLE))
    else $error("byte of unmatched frame delivered");
  AST_FRAME_FLAG: assert property (
    rx_store && MULTIPROC_ENABLE && MULTIPROC_SCHEME_SEL == uau_pkg::SCHEME_ALL
    |=> RX_FRAME_START_FLAG == $past(rx_ninth_q))
    else $error("frame start flag wrong");
  AST_FIRST_DATA: assert property (
    rx_store && MULTIPROC_ENABLE && MULTIPROC_SCHEME_SEL[1] && !is_addr
    |=> FIRST_DATA_OF_FRAME_FLAG == $past(first_pend_q) && !first_pend_q)
    else $error("first data flag wrong");

  COV_BACK_TO_BACK: cover property (tx_state_q == uau_pkg::TX_STOP ##1
                                    tx_state_q == uau_pkg::TX_START);
  COV_OVERRUN: cover property (OVERRUN_ERR && RX_BYTE_AVAILABLE);
  COV_MATCH_DATA: cover property (FIRST_DATA_OF_FRAME_FLAG && RX_BYTE_AVAILABLE);
  COV_BREAK: cover property (LINE_BREAK_FLAG);
endmodule : uau_uart
`default_nettype wire

// ### uau_node.sv
`default_nettype none
// Far-end node on the serial line. The line idles high, as it would with a pull-up.
module uau_node (
  input wire logic clk,
  input wire logic [15:0] div,
  input wire logic txd_in,
  input wire logic de_in,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] rx_q[$];
  logic [8:0] w;
  logic stop_a;
  logic stop_b;
  int rx_len = 8;
  logic rx_two = 1'b0;
  int de_cnt = 0;

  initial rxd_out = 1'b1;

  task automatic wait_t(input int t);
    repeat (t * int'(div)) @(negedge clk);
  endtask : wait_t

  ////////////////////////////////////////////////////////////////////////////////
  // A stop level of 0 after all-zero bits makes a break. One idle bit follows every frame, so the
  // receiver always sees the line high again before the next start.
  task automatic send(input logic [8:0] v, input int len, input logic stop_lvl);
    @(negedge clk);
    rxd_out = 1'b0;
    wait_t(16);
    for (int i = 0; i < len; i++) begin
      rxd_out = v[i];
      wait_t(16);
    end
    rxd_out = stop_lvl;
    wait_t(16);
    rxd_out = 1'b1;
    wait_t(16);
  endtask : send

  ////////////////////////////////////////////////////////////////////////////////
  // Samples each transmitted bit in its middle, LSB first.
  always begin
    @(negedge txd_in);
    wait_t(8);
    w = 9'h000;
    for (int i = 0; i < rx_len; i++) begin
      wait_t(16);
      w[i] = txd_in;
    end
    wait_t(16);
    stop_a = txd_in;
    if (rx_two) begin
      wait_t(16);
      stop_b = txd_in;
    end
    rx_q.push_back(w);
  end

  always @(posedge clk) begin
    if (de_in) begin
      de_cnt <= de_cnt + 1;
    end
  end
endmodule : uau_node
`default_nettype wire

// ### uau_uart_test.sv
`default_nettype none
module uau_uart_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic pe;
    logic po;
    logic ts;
    logic bad;
    logic [7:0] d;
    logic ep;
    logic eperr;
  } uau_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic tx_en = 1'b1;
  logic rx_en = 1'b1;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic two_stop = 1'b0;
  logic tmr = 1'b0;
  logic mp_en = 1'b0;
  logic wr = 1'b0;
  logic tx_addr = 1'b0;
  logic rd = 1'b0;
  logic srd = 1'b0;
  logic irq_en = 1'b1;
  logic [1:0] sch = 2'h0;
  logic [7:0] txdat = 8'h00;
  logic [15:0] div = 16'h0002;
  logic rxd, txd, de, empty, tx_irq, avail, perr, ferr, oerr, brk, fstart, fdata, rx_irq, tev;
  logic [7:0] rx_data;
  int n_mismatch = 0;
  int n_tests = 0;
  uau_row_t rows [4] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 8'hA5, 1'b0, 1'b0},
                         '{1'b1, 1'b0, 1'b1, 1'b0, 8'hA5, 1'b0, 1'b0},
                         '{1'b1, 1'b1, 1'b0, 1'b0, 8'h07, 1'b0, 1'b0},
                         '{1'b1, 1'b0, 1'b0, 1'b1, 8'h07, 1'b1, 1'b1}};
  logic [8:0] mpb [5] = '{9'h133, 9'h044, 9'h15A, 9'h055, 9'h066};
  logic [4:0] irq_m [4] = '{5'h1F, 5'h05, 5'h1C, 5'h18};
  logic [4:0] flg_m [4] = '{5'h05, 5'h05, 5'h08, 5'h08};

  always #20 clk = ~clk;

  uau_uart uau_uart_inst (.CORE_CLK(clk), .ARST_N(arst_n), .TX_ENABLE(tx_en),
    .RX_ENABLE(rx_en), .PARITY_ENABLE(par_en), .PARITY_ODD(par_odd), .TWO_STOP(two_stop),
    .BAUD_DIVIDER(div), .TIMER_MODE(tmr), .MULTIPROC_ENABLE(mp_en),
    .MULTIPROC_SCHEME_SEL(sch), .ADDR_COMPARE(8'h5A), .TX_DATA(txdat), .TX_ADDR_BIT(tx_addr),
    .TX_DATA_WR(wr), .RX_DATA_RD(rd), .STATUS_RD(srd), .RX_DATA_IRQ_EN(irq_en), .RXD(rxd),
    .TXD(txd), .TRANSCEIVER_DRIVE_ENABLE(de), .TX_HOLDING_EMPTY(empty), .TX_IRQ(tx_irq),
    .RX_DATA(rx_data), .RX_BYTE_AVAILABLE(avail), .PARITY_ERR(perr), .FRAMING_ERR(ferr),
    .OVERRUN_ERR(oerr), .LINE_BREAK_FLAG(brk), .RX_FRAME_START_FLAG(fstart),
    .FIRST_DATA_OF_FRAME_FLAG(fdata), .RX_IRQ(rx_irq), .TIMER_EVENT(tev));

  uau_node uau_node_inst (.clk(clk), .div(div), .txd_in(txd), .de_in(de), .rxd_out(rxd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  // A frame that never arrives leaves w unknown, so the byte compare fails too.
  task automatic get_tx(output logic [8:0] w);
    int k;
    k = 0;
    w = 9'hXXX;
    while (uau_node_inst.rx_q.size() == 0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (uau_node_inst.rx_q.size() != 0) begin
      w = uau_node_inst.rx_q.pop_front();
    end
  endtask : get_tx

  task automatic wait_de();
    int k;
    k = 0;
    while (de !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_de

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    uau_row_t r;
    logic [8:0] w;
    int n;
    int k;
    int bt;
    bt = 16 * int'(div);
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("txd idle", 1'b1, txd);
    chk("empty", 1'b1, empty);
    chk("de", 1'b0, de);
    chk("rx data", 8'h00, rx_data);
    chk("avail", 1'b0, avail);
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      par_en = r.pe;
      par_odd = r.po;
      two_stop = r.ts;
      uau_node_inst.rx_len = 8 + r.pe;
      uau_node_inst.rx_two = r.ts;
      uau_node_inst.de_cnt = 0;
      txdat = r.d;
      pulse(wr);
      get_tx(w);
      chk("tx byte", r.d, w[7:0]);
      chk("tx parity", r.pe ? r.ep : 1'b0, w[8]);
      chk("tx stop", 1'b1, uau_node_inst.stop_a);
      chk("tx stop2", 1'b1, r.ts ? uau_node_inst.stop_b : 1'b1);
      wait_de();
      n = (10 + r.pe + r.ts) * bt;
      k = uau_node_inst.de_cnt;
      chk("de span", 1'b1, k >= n - 2 && k <= n + 2);
      uau_node_inst.send({r.ep ^ r.bad, r.d}, 8 + r.pe, 1'b1);
      chk("rx byte", r.d, rx_data);
      chk("parity err", r.eperr, perr);
      chk("rx irq", 1'b1, rx_irq);
      pulse(rd);
      chk("avail", 1'b0, avail);
    end
    $display("format rows done");
    par_en = 1'b0;
    two_stop = 1'b0;
    uau_node_inst.rx_len = 8;
    uau_node_inst.rx_two = 1'b0;
    uau_node_inst.de_cnt = 0;
    txdat = 8'h11;
    pulse(wr);
    chk("empty on write", 1'b0, empty);
    @(negedge clk);
    chk("empty on load", 1'b1, empty);
    txdat = 8'h22;
    pulse(wr);
    chk("empty full", 1'b0, empty);
    get_tx(w);
    chk("tx first", 8'h11, w[7:0]);
    get_tx(w);
    chk("tx second", 8'h22, w[7:0]);
    wait_de();
    k = uau_node_inst.de_cnt;
    chk("de two chars", 1'b1, k >= 20 * bt - 2 && k <= 20 * bt + 2);
    chk("tx irq", 1'b1, tx_irq);
    tx_en = 1'b0;
    txdat = 8'h3C;
    pulse(wr);
    repeat (100) @(negedge clk);
    chk("txd held", 1'b1, txd);
    chk("holding kept", 1'b0, empty);
    chk("tx irq off", 1'b0, tx_irq);
    uau_node_inst.send(9'h096, 8, 1'b1);
    chk("rx alone", 8'h96, rx_data);
    pulse(rd);
    tx_en = 1'b1;
    get_tx(w);
    chk("tx resumed", 8'h3C, w[7:0]);
    rx_en = 1'b0;
    uau_node_inst.send(9'h0C3, 8, 1'b1);
    chk("rx off", 1'b0, avail);
    rx_en = 1'b1;
    $display("transmit test done");
    irq_en = 1'b0;
    uau_node_inst.send(9'h081, 8, 1'b1);
    chk("avail", 1'b1, avail);
    chk("rx irq masked", 1'b0, rx_irq);
    uau_node_inst.send(9'h000, 8, 1'b0);
    chk("held byte", 8'h81, rx_data);
    chk("overrun hidden", 1'b0, oerr);
    chk("break hidden", 1'b0, brk);
    pulse(rd);
    chk("overrun shown", 1'b1, oerr);
    chk("avail again", 1'b1, avail);
    chk("break cause", 1'b1, brk);
    chk("data unchanged", 8'h81, rx_data);
    chk("error irq", 1'b1, rx_irq);
    pulse(srd);
    pulse(rd);
    chk("overrun clr", 1'b0, oerr);
    chk("avail clr", 1'b0, avail);
    chk("break clr", 1'b0, brk);
    uau_node_inst.send(9'h000, 8, 1'b0);
    chk("framing", 1'b1, ferr);
    chk("break", 1'b1, brk);
    chk("break irq", 1'b1, rx_irq);
    pulse(rd);
    chk("framing clr", 1'b0, ferr);
    irq_en = 1'b1;
    $display("error test done");
    mp_en = 1'b1;
    for (int s = 0; s < 4; s++) begin
      sch = s[1:0];
      for (int b = 0; b < 5; b++) begin
        uau_node_inst.send(mpb[b], 9, 1'b1);
        chk("mp irq", irq_m[s][b], rx_irq);
        if (irq_m[s][b]) begin
          chk("mp flag", flg_m[s][b], sch[1] ? fdata : fstart);
          chk("mp data", mpb[b][7:0], rx_data);
          pulse(rd);
        end
      end
    end
    // The transmitter must put the address marker in the ninth bit slot.
    tx_addr = 1'b1;
    txdat = 8'h5A;
    uau_node_inst.rx_len = 9;
    pulse(wr);
    get_tx(w);
    chk("tx addr bit", 9'h15A, w);
    tx_addr = 1'b0;
    uau_node_inst.rx_len = 8;
    mp_en = 1'b0;
    $display("multiprocessor test done");
    // Let the divider reload with the new value first, so that no short
    // interval from the old divider is measured.
    div = 16'h0005;
    repeat (20) @(negedge clk);
    tmr = 1'b1;
    k = 0;
    while (tev !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tev !== 1'b1 && k < 20);
    chk("timer period", 16'h0005, k[15:0]);
    tmr = 1'b0;
    $display("timer test done");
    final_report();
  end
endmodule : uau_uart_test
`default_nettype wire
